// *** design/dlc_loop_cfg.sv ***
/*
 Configuration bank of two loop channels behind an Avalon-MM slave.
 Assumes word addressing, bus and user logic on clk_i; holdover is a pin.
*/
// Added by the designer: register access over Avalon-MM.
// Function
// - The 30-bit feedback integer is built from four bytes, top byte six bits, low address high.
// - The 40-bit feedback fraction is built from five bytes, lowest address most significant.
// - The modulator order is bits 2:0 of its register; the upper bits do nothing.
// - Always-hitless one with fast-lock zero makes every switchover hitless.
// - Always-hitless zero with fast-lock forced makes switchovers use fast lock.
// - Both zero: hitless if holdover time is below the timer, otherwise fast lock.
// - Holdover policy zero selects the free-run word, one holds the last control value.
// - The two-bit topology field selects single, two-loop ref, two-loop osc or three-loop.
// - The switchover timer exponent is bits 4:0 of its own register.
// - The 11-bit timer mantissa keeps bits 10:8 in one register and 7:0 in the next.
// - Each input divider is 16 bits from two bytes with the high byte at the lower address.
// - The feedback prescale field gives a divide ratio of its value plus two.
module dlc_loop_cfg
    import dlc_pkg::*;
#(
    parameter int HOLD_CNT_W = LIMIT_W
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [8:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        holdover_pin_i,
    input  wire logic        history_valid_i,
    input  wire logic        switch_req_i,
    output dlc_ch1_cfg_t     ch1_cfg_o,
    output dlc_ch2_cfg_t     ch2_cfg_o,
    output dlc_switch_dec_t  switch_dec_o,
    output logic             freerun_word_sel_o,
    output logic             hold_last_sel_o
);

    typedef struct packed {
        dlc_bank_t   bank;
        logic        ack;
        logic [31:0] rdata;
        logic [4:0]  ratio;
        logic        freerun;
        logic        hold_last;
    } dlc_state_t;

    dlc_state_t      s_q;
    dlc_state_t      s_d;
    logic            req;
    logic            wr_acc;
    logic [5:0]      slot;
    logic            holdover;
    dlc_switch_dec_t dec;
    logic [2:0]      status;

    assign req               = avs_read_i || avs_write_i;
    // One wait cycle, so read data can come from a flop
    assign avs_waitrequest_o = req && !s_q.ack;
    assign wr_acc            = avs_write_i && s_q.ack;
    assign slot              = dlc_slot(avs_address_i);
    assign status            = {dec.fast, dec.hitless, holdover};

    always_comb begin
        s_d = s_q;
        s_d.ack = req && !s_q.ack;
        if (req && !s_q.ack && avs_read_i) begin
            if (slot[5]) begin
                s_d.rdata = {24'h000000, s_q.bank.b[slot[4:0]]};
            end else if (avs_address_i == IDX_STATUS) begin
                s_d.rdata = {29'h00000000, status};
            end else begin
                s_d.rdata = 32'h00000000;
            end
        end
        if (wr_acc && avs_byteenable_i[0] && slot[5]) begin
            s_d.bank.b[slot[4:0]] = avs_writedata_i[7:0] & WMASK[slot[4:0]];
        end
        s_d.ratio = 5'(s_q.bank.f.prescale_ctl[PRESCALE_MSB:0]) + PRESCALE_BIAS;
        s_d.freerun   = holdover && !history_valid_i
                        && !s_q.bank.f.loop_switch_policy_ctl[BIT_HOLD_POLICY];
        s_d.hold_last = holdover && !history_valid_i
                        && s_q.bank.f.loop_switch_policy_ctl[BIT_HOLD_POLICY];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        ch1_cfg_o.ch1_osc_feedback_int = {
            s_q.bank.f.fb_div_int_byte3[INT_TOP_MSB:0],
            s_q.bank.f.fb_div_int_byte2,
            s_q.bank.f.fb_div_int_byte1,
            s_q.bank.f.fb_div_int_byte0};
        ch1_cfg_o.ch1_osc_feedback_frac = {
            s_q.bank.f.fb_frac_num_byte4,
            s_q.bank.f.fb_frac_num_byte3,
            s_q.bank.f.fb_frac_num_byte2,
            s_q.bank.f.fb_frac_num_byte1,
            s_q.bank.f.fb_frac_num_byte0};
        ch1_cfg_o.ch1_modulator_order =
            s_q.bank.f.modulator_order_ctl[ORDER_MSB:0];
        ch1_cfg_o.ch1_feedback_prescale = s_q.ratio;
    end

    always_comb begin
        ch2_cfg_o.ch2_always_hitless_switch =
            s_q.bank.f.loop_switch_policy_ctl[BIT_ALWAYS_HITLESS];
        ch2_cfg_o.ch2_force_fast_acquire =
            s_q.bank.f.loop_switch_policy_ctl[BIT_FORCE_FAST];
        ch2_cfg_o.ch2_holdover_policy =
            s_q.bank.f.loop_switch_policy_ctl[BIT_HOLD_POLICY];
        ch2_cfg_o.ch2_loop_topology =
            s_q.bank.f.loop_switch_policy_ctl[TOPO_MSB:0];
        ch2_cfg_o.ch2_switch_timer_exponent =
            s_q.bank.f.switch_timer_exponent[EXP_MSB:0];
        ch2_cfg_o.ch2_switch_timer_mantissa = {
            s_q.bank.f.switch_timer_mant_high[MANT_HIGH_MSB:0],
            s_q.bank.f.switch_timer_mant_low};
        ch2_cfg_o.ch2_input0_divider = {s_q.bank.f.ref0_divider_high,
                                        s_q.bank.f.ref0_divider_low};
        ch2_cfg_o.ch2_input1_divider = {s_q.bank.f.ref1_divider_high,
                                        s_q.bank.f.ref1_divider_low};
        ch2_cfg_o.ch2_input2_divider = {s_q.bank.f.ref2_divider_high,
                                        s_q.bank.f.ref2_divider_low};
    end

    // Holdover timer and switch decision share the policy bits
    dlc_switch_policy #(
        .CNT_W (HOLD_CNT_W)
    ) u_policy (
        .clk_i            (clk_i),
        .rst_i            (rst_i),
        .holdover_pin_i   (holdover_pin_i),
        .switch_req_i     (switch_req_i),
        .always_hitless_i (ch2_cfg_o.ch2_always_hitless_switch),
        .force_fast_i     (ch2_cfg_o.ch2_force_fast_acquire),
        .exp_i            (ch2_cfg_o.ch2_switch_timer_exponent),
        .mant_i           (ch2_cfg_o.ch2_switch_timer_mantissa),
        .holdover_o       (holdover),
        .dec_o            (dec)
    );

    assign avs_readdata_o     = s_q.rdata;
    assign switch_dec_o       = dec;
    assign freerun_word_sel_o = s_q.freerun;
    assign hold_last_sel_o    = s_q.hold_last;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    bus_one_wait_a: assert property (
        req && !avs_waitrequest_o |-> $past(avs_waitrequest_o))
        else $error("answer came without one wait cycle");
    int_low_byte_a: assert property (
        wr_acc && avs_byteenable_i[0] && avs_address_i == IDX_INT_BYTE0
        |=> ch1_cfg_o.ch1_osc_feedback_int[7:0] == $past(avs_writedata_i[7:0]))
        else $error("integer low byte not taken");
    int_top_byte_a: assert property (
        wr_acc && avs_byteenable_i[0] && avs_address_i == IDX_INT_BYTE3
        |=> ch1_cfg_o.ch1_osc_feedback_int[29:24] == $past(avs_writedata_i[5:0]))
        else $error("integer top bits not taken");
    frac_top_byte_a: assert property (
        wr_acc && avs_byteenable_i[0] && avs_address_i == IDX_FRAC_BYTE4
        |=> ch1_cfg_o.ch1_osc_feedback_frac[39:32] == $past(avs_writedata_i[7:0]))
        else $error("fraction top byte not taken");
    order_field_a: assert property (
        wr_acc && avs_byteenable_i[0] && avs_address_i == IDX_ORDER
        |=> ch1_cfg_o.ch1_modulator_order == $past(avs_writedata_i[2:0])
            && !s_q.bank.f.modulator_order_ctl[7])
        else $error("order field wrong");
    mant_high_bits_a: assert property (
        wr_acc && avs_byteenable_i[0] && avs_address_i == IDX_MANT_HIGH
        |=> ch2_cfg_o.ch2_switch_timer_mantissa[10:8] == $past(avs_writedata_i[2:0]))
        else $error("mantissa high bits not taken");
    ref1_high_byte_a: assert property (
        wr_acc && avs_byteenable_i[0] && avs_address_i == IDX_REF1_HIGH
        |=> ch2_cfg_o.ch2_input1_divider[15:8] == $past(avs_writedata_i[7:0]))
        else $error("input divider high byte not taken");
    prescale_ratio_a: assert property (
        wr_acc && avs_byteenable_i[0] && avs_address_i == IDX_PRESCALE
        |=> ##1 ch1_cfg_o.ch1_feedback_prescale
            == 5'($past(avs_writedata_i[3:0], 2)) + 5'h02)
        else $error("prescale ratio not value plus two");
    freerun_select_a: assert property (
        holdover && !history_valid_i && !ch2_cfg_o.ch2_holdover_policy
        |=> freerun_word_sel_o && !hold_last_sel_o)
        else $error("free-run word not selected");
    hold_last_select_a: assert property (
        holdover && !history_valid_i && ch2_cfg_o.ch2_holdover_policy
        |=> hold_last_sel_o && !freerun_word_sel_o)
        else $error("hold-last value not selected");
    topology_field_a: assert property (
        wr_acc && avs_byteenable_i[0] && avs_address_i == IDX_POLICY
        |=> ch2_cfg_o.ch2_loop_topology == $past(avs_writedata_i[1:0]))
        else $error("loop topology field not taken");
    exp_field_a: assert property (
        wr_acc && avs_byteenable_i[0] && avs_address_i == IDX_TMR_EXP
        |=> ch2_cfg_o.ch2_switch_timer_exponent == $past(avs_writedata_i[4:0]))
        else $error("timer exponent field not taken");

endmodule : dlc_loop_cfg

// *** design/dlc_pkg.sv ***
/*
 Constants, register map and carrier types of the loop configuration bank.
 Assumes a 10 MHz clock and an Avalon-MM host using word addresses.
*/
package dlc_pkg;

    // Register indexes; the bus word address equals the index
    localparam logic [8:0] IDX_PRESCALE   = 9'h1ae;
    localparam logic [8:0] IDX_INT_BYTE3  = 9'h1af;
    localparam logic [8:0] IDX_INT_BYTE2  = 9'h1b0;
    localparam logic [8:0] IDX_INT_BYTE1  = 9'h1b1;
    localparam logic [8:0] IDX_INT_BYTE0  = 9'h1b2;
    localparam logic [8:0] IDX_FRAC_BYTE4 = 9'h1b3;
    localparam logic [8:0] IDX_FRAC_BYTE3 = 9'h1b4;
    localparam logic [8:0] IDX_FRAC_BYTE2 = 9'h1b5;
    localparam logic [8:0] IDX_FRAC_BYTE1 = 9'h1b6;
    localparam logic [8:0] IDX_FRAC_BYTE0 = 9'h1b7;
    localparam logic [8:0] IDX_ORDER      = 9'h1b8;
    localparam logic [8:0] IDX_POLICY     = 9'h1b9;
    localparam logic [8:0] IDX_TMR_EXP    = 9'h1ba;
    localparam logic [8:0] IDX_MANT_HIGH  = 9'h1bb;
    localparam logic [8:0] IDX_MANT_LOW   = 9'h1bc;
    localparam logic [8:0] IDX_REF0_HIGH  = 9'h1bd;
    localparam logic [8:0] IDX_REF0_LOW   = 9'h1be;
    localparam logic [8:0] IDX_REF1_HIGH  = 9'h1bf;
    localparam logic [8:0] IDX_REF1_LOW   = 9'h1c0;
    localparam logic [8:0] IDX_REF2_HIGH  = 9'h1c1;
    localparam logic [8:0] IDX_REF2_LOW   = 9'h1c2;
    localparam logic [8:0] IDX_STATUS     = 9'h1e0;
    localparam logic [8:0] IDX_FIRST      = IDX_PRESCALE;
    localparam logic [8:0] IDX_LAST       = IDX_REF2_LOW;
    localparam int         NREG           = 21;

    // Writable bits per register, highest index first
    localparam logic [NREG-1:0][7:0] WMASK = {
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'h07, 8'h1f, 8'hff, 8'h7f,
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'hff, 8'hff, 8'hff, 8'h3f, 8'h0f};
    localparam logic [7:0] REG_RST = 8'h00;

    // Field positions
    localparam int BIT_ALWAYS_HITLESS = 5;
    localparam int BIT_FORCE_FAST     = 4;
    localparam int BIT_HOLD_POLICY    = 2;
    localparam int TOPO_MSB           = 1;
    localparam int ORDER_MSB          = 2;
    localparam int EXP_MSB            = 4;
    localparam int MANT_HIGH_MSB      = 2;
    localparam int INT_TOP_MSB        = 5;
    localparam int PRESCALE_MSB       = 3;
    localparam logic [4:0] PRESCALE_BIAS = 5'h02;

    // Loop topology codes
    localparam logic [1:0] TOPO_SINGLE   = 2'h0;
    localparam logic [1:0] TOPO_REF_LOCK = 2'h1;
    localparam logic [1:0] TOPO_OSC_LOCK = 2'h2;
    localparam logic [1:0] TOPO_TRIPLE   = 2'h3;

    localparam int LIMIT_W = 42;

    // Field view: lowest index is the least significant byte
    typedef struct packed {
        logic [7:0] ref2_divider_low;
        logic [7:0] ref2_divider_high;
        logic [7:0] ref1_divider_low;
        logic [7:0] ref1_divider_high;
        logic [7:0] ref0_divider_low;
        logic [7:0] ref0_divider_high;
        logic [7:0] switch_timer_mant_low;
        logic [7:0] switch_timer_mant_high;
        logic [7:0] switch_timer_exponent;
        logic [7:0] loop_switch_policy_ctl;
        logic [7:0] modulator_order_ctl;
        logic [7:0] fb_frac_num_byte0;
        logic [7:0] fb_frac_num_byte1;
        logic [7:0] fb_frac_num_byte2;
        logic [7:0] fb_frac_num_byte3;
        logic [7:0] fb_frac_num_byte4;
        logic [7:0] fb_div_int_byte0;
        logic [7:0] fb_div_int_byte1;
        logic [7:0] fb_div_int_byte2;
        logic [7:0] fb_div_int_byte3;
        logic [7:0] prescale_ctl;
    } dlc_bank_fields_t;

    typedef union packed {
        dlc_bank_fields_t           f;
        logic [NREG-1:0][7:0]       b;
    } dlc_bank_t;

    typedef struct packed {
        logic [29:0] ch1_osc_feedback_int;
        logic [39:0] ch1_osc_feedback_frac;
        logic [2:0]  ch1_modulator_order;
        logic [4:0]  ch1_feedback_prescale;
    } dlc_ch1_cfg_t;

    typedef struct packed {
        logic        ch2_always_hitless_switch;
        logic        ch2_force_fast_acquire;
        logic        ch2_holdover_policy;
        logic [1:0]  ch2_loop_topology;
        logic [4:0]  ch2_switch_timer_exponent;
        logic [10:0] ch2_switch_timer_mantissa;
        logic [15:0] ch2_input0_divider;
        logic [15:0] ch2_input1_divider;
        logic [15:0] ch2_input2_divider;
    } dlc_ch2_cfg_t;

    typedef struct packed {
        logic valid;
        logic hitless;
        logic fast;
    } dlc_switch_dec_t;

    // Decode of a word address into {hit, slot}
    function automatic logic [5:0] dlc_slot(input logic [8:0] idx);
        if (idx >= IDX_FIRST && idx <= IDX_LAST) begin
            return {1'b1, 5'(idx - IDX_FIRST)};
        end
        return 6'h00;
    endfunction : dlc_slot

    // Switchover timer length: mantissa scaled by two to the exponent
    function automatic logic [LIMIT_W-1:0] dlc_timer_limit(input logic [4:0]  e,
                                                           input logic [10:0] m);
        return LIMIT_W'(m) << e;
    endfunction : dlc_timer_limit

endpackage : dlc_pkg

// *** design/dlc_switch_policy.sv ***
/*
 Switchover policy of the second channel: holdover timer and decision.
 Assumes holdover_pin_i is asynchronous and switch_req_i is a clk_i pulse.
*/
module dlc_switch_policy
    import dlc_pkg::*;
#(
    parameter int CNT_W = LIMIT_W
) (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            holdover_pin_i,
    input  wire logic            switch_req_i,
    input  wire logic            always_hitless_i,
    input  wire logic            force_fast_i,
    input  wire logic [4:0]      exp_i,
    input  wire logic [10:0]     mant_i,
    output logic                 holdover_o,
    output dlc_switch_dec_t      dec_o
);

    typedef struct packed {
        logic [1:0]       sync;
        logic             prev;
        logic [CNT_W-1:0] count;
        dlc_switch_dec_t  dec;
    } dlc_sp_state_t;

    dlc_sp_state_t s_q;
    dlc_sp_state_t s_d;
    logic          short_hold;

    always_comb begin
        s_d = s_q;
        s_d.sync = {s_q.sync[0], holdover_pin_i};
        s_d.prev = s_q.sync[1];
        // Time restarts on each entry, kept after exit for the switch
        if (s_q.sync[1] && !s_q.prev) begin
            s_d.count = '0;
        end else if (s_q.sync[1] && s_q.count != '1) begin
            s_d.count = s_q.count + CNT_W'(1);
        end
        short_hold = LIMIT_W'(s_q.count) < dlc_timer_limit(exp_i, mant_i);
        s_d.dec.valid = switch_req_i;
        if (switch_req_i) begin
            if (always_hitless_i && !force_fast_i) begin
                s_d.dec.hitless = 1'b1;
            end else if (!always_hitless_i && !force_fast_i) begin
                s_d.dec.hitless = short_hold;
            end else begin
                s_d.dec.hitless = 1'b0;
            end
            s_d.dec.fast = !s_d.dec.hitless;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign holdover_o = s_q.sync[1];
    assign dec_o      = s_q.dec;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    force_fast_dec_a: assert property (
        switch_req_i && force_fast_i && !always_hitless_i
        |=> dec_o.valid && dec_o.fast && !dec_o.hitless)
        else $error("forced fast lock not chosen");
    hitless_dec_a: assert property (
        switch_req_i && always_hitless_i && !force_fast_i
        |=> dec_o.valid && dec_o.hitless && !dec_o.fast)
        else $error("hitless switch not chosen");
    timer_dec_a: assert property (
        switch_req_i && !always_hitless_i && !force_fast_i
        |=> dec_o.hitless == $past(short_hold))
        else $error("holdover timer decision wrong");

endmodule : dlc_switch_policy

// *** tb/dlc_loop_cfg_tb.sv ***
/*
 Self-checking bench of the loop configuration bank, driving its ports directly.
 Assumes one 10 MHz clock, synchronous reset, and assertions inside the design.
*/
module dlc_loop_cfg_tb;
    import dlc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic            clk_i;
    logic            rst_i;
    logic [8:0]      avs_address_i;
    logic            avs_read_i;
    logic            avs_write_i;
    logic [31:0]     avs_writedata_i;
    logic [3:0]      avs_byteenable_i;
    logic [31:0]     avs_readdata_o;
    logic            avs_waitrequest_o;
    logic            holdover_pin_i;
    logic            history_valid_i;
    logic            switch_req_i;
    dlc_ch1_cfg_t    ch1_cfg_o;
    dlc_ch2_cfg_t    ch2_cfg_o;
    dlc_switch_dec_t switch_dec_o;
    logic            freerun_word_sel_o;
    logic            hold_last_sel_o;
    int              num_errors = 0;
    int              checked = 0;
    int              cycles = 0;

    // Small holdover counter keeps the timer comparison short
    dlc_loop_cfg #(.HOLD_CNT_W(16)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .holdover_pin_i(holdover_pin_i), .history_valid_i(history_valid_i),
        .switch_req_i(switch_req_i), .ch1_cfg_o(ch1_cfg_o), .ch2_cfg_o(ch2_cfg_o),
        .switch_dec_o(switch_dec_o), .freerun_word_sel_o(freerun_word_sel_o),
        .hold_last_sel_o(hold_last_sel_o));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    // Whole run needs well under this many cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            final_report();
        end
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic [8:0] a, input logic wr, input logic [7:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        logic w;
        @(posedge clk_i);
        avs_address_i    <= a;
        avs_write_i      <= wr;
        avs_read_i       <= !wr;
        avs_writedata_i  <= {24'h000000, d};
        avs_byteenable_i <= be;
        // Reads here see what this edge samples, not what it launches
        do begin
            @(posedge clk_i);
            w = avs_waitrequest_o;
            q = avs_readdata_o;
        end while (w !== 1'b0);
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
    endtask : bus

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, 4'hf, q);
    endtask : wr

    task automatic rd(input logic [8:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(a, 1'b0, 8'h00, 4'hf, q);
        chk(q, exp);
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(negedge clk_i);
    endtask : settle

    task automatic t_ch1();
        wr(IDX_INT_BYTE3, 8'hff);
        wr(IDX_INT_BYTE2, 8'ha5);
        wr(IDX_INT_BYTE1, 8'h5a);
        wr(IDX_INT_BYTE0, 8'hc3);
        for (int i = 0; i < 5; i++) begin
            wr(IDX_FRAC_BYTE4 + 9'(i), 8'h12 + 8'(i * 8'h22));
        end
        wr(IDX_ORDER, 8'hff);
        wr(IDX_PRESCALE, 8'hff);
        settle(3);
        chk(ch1_cfg_o.ch1_osc_feedback_int, 64'h3fa55ac3);
        chk(ch1_cfg_o.ch1_osc_feedback_frac, 64'h123456789a);
        chk(ch1_cfg_o.ch1_modulator_order, 64'h7);
        chk(ch1_cfg_o.ch1_feedback_prescale, 64'h11);
        rd(IDX_INT_BYTE3, 32'h0000003f);
        rd(IDX_ORDER, 32'h0000007f);
        wr(IDX_PRESCALE, 8'h00);
        settle(3);
        chk(ch1_cfg_o.ch1_feedback_prescale, 64'h02);
    endtask : t_ch1

    task automatic t_ch2();
        logic [31:0] q;
        wr(IDX_TMR_EXP, 8'hff);
        wr(IDX_MANT_HIGH, 8'hff);
        wr(IDX_MANT_LOW, 8'h9c);
        for (int i = 0; i < 6; i++) begin
            wr(IDX_REF0_HIGH + 9'(i), 8'h11 * 8'(i + 1));
        end
        settle(2);
        chk(ch2_cfg_o.ch2_switch_timer_exponent, 64'h1f);
        chk(ch2_cfg_o.ch2_switch_timer_mantissa, 64'h79c);
        rd(IDX_TMR_EXP, 32'h0000001f);
        rd(IDX_MANT_HIGH, 32'h00000007);
        chk(ch2_cfg_o.ch2_input0_divider, 64'h1122);
        chk(ch2_cfg_o.ch2_input1_divider, 64'h3344);
        chk(ch2_cfg_o.ch2_input2_divider, 64'h5566);
        for (int i = 0; i < 4; i++) begin
            wr(IDX_POLICY, 8'(i));
            settle(2);
            chk(ch2_cfg_o.ch2_loop_topology, 64'(i));
        end
        // Unmapped place and a write with its byte lane off both leave state alone
        wr(9'h1c3, 8'hff);
        rd(9'h1c3, 32'h00000000);
        bus(IDX_REF0_LOW, 1'b1, 8'hee, 4'h0, q);
        rd(IDX_REF0_LOW, 32'h00000022);
    endtask : t_ch2

    task automatic sw(input logic hl, input logic fs);
        @(posedge clk_i);
        switch_req_i <= 1'b1;
        @(posedge clk_i);
        switch_req_i <= 1'b0;
        @(negedge clk_i);
        chk(switch_dec_o.valid, 64'h1);
        chk(switch_dec_o.hitless, 64'(hl));
        chk(switch_dec_o.fast, 64'(fs));
        @(negedge clk_i);
        chk(switch_dec_o.valid, 64'h0);
    endtask : sw

    task automatic t_switch();
        wr(IDX_TMR_EXP, 8'h00);
        wr(IDX_MANT_HIGH, 8'h00);
        wr(IDX_MANT_LOW, 8'h14);
        wr(IDX_POLICY, 8'h00);
        @(posedge clk_i);
        holdover_pin_i <= 1'b1;
        settle(6);
        sw(1'b1, 1'b0);
        settle(40);
        sw(1'b0, 1'b1);
        wr(IDX_POLICY, 8'h20);
        sw(1'b1, 1'b0);
        wr(IDX_POLICY, 8'h10);
        sw(1'b0, 1'b1);
        // Status: fast set, hitless clear, holdover seen
        rd(IDX_STATUS, 32'h00000005);
        // Both policy bits set: fast lock wins
        wr(IDX_POLICY, 8'h30);
        sw(1'b0, 1'b1);
        rd(IDX_STATUS, 32'h00000005);
        @(posedge clk_i);
        holdover_pin_i <= 1'b0;
        settle(5);
    endtask : t_switch

    task automatic t_hold();
        wr(IDX_POLICY, 8'h00);
        @(posedge clk_i);
        history_valid_i <= 1'b0;
        holdover_pin_i  <= 1'b1;
        settle(5);
        chk(freerun_word_sel_o, 64'h1);
        chk(hold_last_sel_o, 64'h0);
        wr(IDX_POLICY, 8'h04);
        settle(2);
        chk(freerun_word_sel_o, 64'h0);
        chk(hold_last_sel_o, 64'h1);
        @(posedge clk_i);
        history_valid_i <= 1'b1;
        settle(2);
        chk(hold_last_sel_o, 64'h0);
    endtask : t_hold

    initial begin
        rst_i            = 1'b1;
        avs_address_i    = 9'h000;
        avs_read_i       = 1'b0;
        avs_write_i      = 1'b0;
        avs_writedata_i  = 32'h00000000;
        avs_byteenable_i = 4'hf;
        holdover_pin_i   = 1'b0;
        history_valid_i  = 1'b1;
        switch_req_i     = 1'b0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_ch1();
        t_ch2();
        t_switch();
        t_hold();
        final_report();
    end
endmodule : dlc_loop_cfg_tb
